// [logic/lcr_defines.svh]
// Constants for the line driver configuration register bank.
// Included by every design module; holds definitions only.
`ifndef LCR_DEFINES_SVH
`define LCR_DEFINES_SVH
`define LCR_ADDR_STATUS 5'h02
`define LCR_ADDR_MODE 5'h04
`define LCR_ADDR_LIMIT 5'h05
`define LCR_ADDR_CTRL 5'h06
`define LCR_ADDR_DRV 5'h07
`define LCR_CFG_RESET 8'h00
`define LCR_CTRL_MASK 8'hCD
`define LCR_MODE_RST 7
`define LCR_STATUS_FAULT 4
`define LCR_LIM_LEVEL 7:6
`define LCR_LIM_DIS 5
`define LCR_LIM_BLANK 4:3
`define LCR_LIM_OFF 2:1
`define LCR_LIM_RETRY 0
`define LCR_CTRL_AUX_OFF 7
`define LCR_CTRL_WAKE_OFF 6
`define LCR_CTRL_RX_OFF 3
`define LCR_CTRL_FILTER 2
`define LCR_CTRL_LEVEL 0
`define LCR_DRV_EDGE 7:6
`define LCR_DRV_PD 5
`define LCR_DRV_PU 4
`define LCR_DRV_SINK 3
`define LCR_DRV_PP 2
`define LCR_DRV_POL 1
`define LCR_DRV_EN 0
`define LCR_EDGE_FASTEST 2'h0
`define LCR_SPI_CMD_LAST 4'h7
`define LCR_SPI_FRAME_LAST 4'hF
`define LCR_SPI_CMD_READ 6
`define LCR_SYNC_W 7
`define LCR_SYNC_RST 7'h02
`define LCR_SY_SCLK 0
`define LCR_SY_CS 1
`define LCR_SY_SDI 2
`define LCR_SY_TX 3
`define LCR_SY_LINE 4
`define LCR_SY_OC 5
`define LCR_SY_TH 6
`define LCR_CLK_MHZ 20
`define LCR_CLK_KHZ 20000
`define LCR_GLITCH_US 1
`define LCR_BLANK_0_US 175
`define LCR_BLANK_1_US 500
`define LCR_BLANK_2_MS 1
`define LCR_BLANK_3_MS 5
`define LCR_OFF_0_MS 50
`define LCR_OFF_1_MS 100
`define LCR_OFF_2_MS 200
`define LCR_OFF_3_MS 500
`endif

// [logic/lcr_pkg.sv]
// Types shared by the line driver configuration design files.
// No numbers live here; offsets and timings are in the defines header.
package lcr_pkg;
  typedef enum logic [1:0] {
    FS_RUN = 2'h0,
    FS_BLANK = 2'h1,
    FS_OFF = 2'h2,
    FS_HOLD = 2'h3
  } lcr_fault_state_type;
  typedef enum logic [1:0] {
    DM_SOURCE = 2'h0,
    DM_SINK = 2'h1,
    DM_PUSH_PULL = 2'h2
  } lcr_drive_mode_type;
endpackage

// [logic/lcr_spi_port.sv]
// Serial register port: 16-bit frames, mode 0, command byte then data.
// Assumes pins already synchronised; sclk well below clk/4.
`timescale 1ns/100ps
`include "lcr_defines.svh"
module lcr_spi_port (
  input logic clk,
  input logic rst_n,
  input logic sclk_s,
  input logic cs_n_s,
  input logic sdi_s,
  input logic [7:0] rd_data,
  output logic [4:0] addr,
  output logic wr_pulse,
  output logic [7:0] wr_data,
  output logic sdo,
  output logic sdo_oe
);
  logic sclk_prev_reg;
  logic [3:0] cnt_reg;
  logic [6:0] rx_shift_reg;
  logic [7:0] tx_shift_reg;
  logic is_read_reg;
  logic load_reg;
  logic rise;
  logic fall;

  assign rise = sclk_s & ~sclk_prev_reg;
  assign fall = ~sclk_s & sclk_prev_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      rx_shift_reg <= 7'h00;
      addr <= 5'h00;
      is_read_reg <= 1'b0;
      load_reg <= 1'b0;
      wr_pulse <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      load_reg <= 1'b0;
      if (cs_n_s) begin
        cnt_reg <= 4'h0;
      end else if (rise) begin
        rx_shift_reg <= {rx_shift_reg[5:0], sdi_s};
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == `LCR_SPI_CMD_LAST) begin
          addr <= {rx_shift_reg[3:0], sdi_s};
          is_read_reg <= rx_shift_reg[`LCR_SPI_CMD_READ];
          load_reg <= 1'b1;
        end
        if (cnt_reg == `LCR_SPI_FRAME_LAST && !is_read_reg) begin
          wr_pulse <= 1'b1;
          wr_data <= {rx_shift_reg, sdi_s};
        end
      end
    end
  end

  // Read data leaves on falling edges so the host samples it on rising ones
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_shift_reg <= 8'h00;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= ~cs_n_s;
      if (load_reg) begin
        tx_shift_reg <= rd_data;
      end else if (fall && !cs_n_s && cnt_reg[3]) begin
        sdo <= tx_shift_reg[7];
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
    end
  end
endmodule

// [logic/lcr_fault_ctrl.sv]
// Driver overload supervisor: blanking, fault latch and retry off-time.
// Assumes overload inputs are synchronised to clk.
`timescale 1ns/100ps
`include "lcr_defines.svh"
module lcr_fault_ctrl import lcr_pkg::*; #(
  parameter int CNT_W = 24,
  parameter int BLANK_CYC_0 = 3500,
  parameter int BLANK_CYC_1 = 10000,
  parameter int BLANK_CYC_2 = 20000,
  parameter int BLANK_CYC_3 = 100000,
  parameter int OFF_CYC_0 = 1000000,
  parameter int OFF_CYC_1 = 2000000,
  parameter int OFF_CYC_2 = 4000000,
  parameter int OFF_CYC_3 = 10000000
) (
  input logic clk,
  input logic rst_n,
  input logic cfg_reset,
  input logic overcurrent,
  input logic thermal,
  input logic drive_on,
  input logic retry_en,
  input logic [1:0] blank_sel,
  input logic [1:0] off_sel,
  input logic sw_rearm,
  output logic allowed,
  output logic fault_flag
);
  lcr_fault_state_type state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] blank_lim;
  logic [CNT_W-1:0] off_lim;

  if (BLANK_CYC_0 < 2 || OFF_CYC_0 < 2 || BLANK_CYC_3 >= 2**CNT_W
      || OFF_CYC_3 >= 2**CNT_W) begin : g_bad_count
    $error("Fault timing counts do not fit the counter");
  end

  function automatic logic [CNT_W-1:0] pick(input logic [1:0] sel, input int c0,
      input int c1, input int c2, input int c3);
    int v;
    v = c0;
    case (sel)
      2'h1: v = c1;
      2'h2: v = c2;
      2'h3: v = c3;
      default: v = c0;
    endcase
    return CNT_W'(v - 1);
  endfunction

  assign blank_lim = pick(blank_sel, BLANK_CYC_0, BLANK_CYC_1, BLANK_CYC_2, BLANK_CYC_3);
  assign off_lim = pick(off_sel, OFF_CYC_0, OFF_CYC_1, OFF_CYC_2, OFF_CYC_3);
  assign allowed = (state_reg == FS_RUN) || (state_reg == FS_BLANK);

  // A thermal overload in the clearing cycle keeps the fault set
  always_ff @(posedge clk) begin
    if (!rst_n || cfg_reset) begin
      state_reg <= FS_RUN;
      cnt_reg <= '0;
      fault_flag <= 1'b0;
    end else begin
      case (state_reg)
        FS_RUN: begin
          cnt_reg <= '0;
          if (thermal) begin
            fault_flag <= 1'b1;
            state_reg <= retry_en ? FS_OFF : FS_HOLD;
          end else if (overcurrent && drive_on) begin
            state_reg <= FS_BLANK;
          end
        end
        FS_BLANK: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (thermal || (overcurrent && cnt_reg == blank_lim)) begin
            fault_flag <= 1'b1;
            cnt_reg <= '0;
            state_reg <= retry_en ? FS_OFF : FS_HOLD;
          end else if (!overcurrent || !drive_on) begin
            cnt_reg <= '0;
            state_reg <= FS_RUN;
          end
        end
        FS_OFF: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == off_lim) begin
            cnt_reg <= '0;
            if (!thermal) begin
              fault_flag <= 1'b0;
              state_reg <= FS_RUN;
            end
          end
        end
        FS_HOLD: begin
          if (sw_rearm && !thermal) begin
            fault_flag <= 1'b0;
            state_reg <= FS_RUN;
          end
        end
        default: state_reg <= FS_RUN;
      endcase
    end
  end

  AST_BLANK_FULL: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(fault_flag) && !$past(cfg_reset) |-> $past(thermal)
    || ($past(state_reg) == FS_BLANK && $past(cnt_reg) == $past(blank_lim)))
    else $error("Fault declared before blanking expired");
  AST_RETRY_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(fault_flag) && $past(retry_en) && !$past(cfg_reset) |-> state_reg == FS_OFF
    ##1 !allowed) else $error("Retry fault did not switch driver off");
  AST_OFF_END: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == FS_OFF && cnt_reg == off_lim && !thermal && !cfg_reset
    |=> state_reg == FS_RUN && !fault_flag) else $error("Off-time did not end");
  AST_HOLD_STAYS: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == FS_HOLD && !sw_rearm && !cfg_reset |=> state_reg == FS_HOLD
    && fault_flag) else $error("Held fault released without software");
  COV_RETRY: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == FS_OFF ##1 state_reg == FS_RUN);
endmodule

// [logic/lcr_line_driver_regs.sv]
// Line driver configuration register bank with serial register port.
// Assumes all pins asynchronous to clk; analog blocks act on the outputs.
`timescale 1ns/100ps
`include "lcr_defines.svh"
module lcr_line_driver_regs import lcr_pkg::*; #(
  parameter int FILT_W = 5,
  parameter int GLITCH_CYC = `LCR_GLITCH_US * `LCR_CLK_MHZ,
  parameter int CNT_W = 24,
  parameter int BLANK_CYC_0 = `LCR_BLANK_0_US * `LCR_CLK_MHZ,
  parameter int BLANK_CYC_1 = `LCR_BLANK_1_US * `LCR_CLK_MHZ,
  parameter int BLANK_CYC_2 = `LCR_BLANK_2_MS * `LCR_CLK_KHZ,
  parameter int BLANK_CYC_3 = `LCR_BLANK_3_MS * `LCR_CLK_KHZ,
  parameter int OFF_CYC_0 = `LCR_OFF_0_MS * `LCR_CLK_KHZ,
  parameter int OFF_CYC_1 = `LCR_OFF_1_MS * `LCR_CLK_KHZ,
  parameter int OFF_CYC_2 = `LCR_OFF_2_MS * `LCR_CLK_KHZ,
  parameter int OFF_CYC_3 = `LCR_OFF_3_MS * `LCR_CLK_KHZ
) (
  input logic clk,
  input logic rst_n,
  input logic sclk,
  input logic cs_n,
  input logic sdi,
  input logic tx_in,
  input logic line_in,
  input logic overcurrent,
  input logic thermal_overload,
  output logic sdo,
  output logic sdo_oe,
  output logic line_driver_on,
  output logic driver_level,
  output lcr_drive_mode_type drive_mode,
  output logic [1:0] driver_edge_rate,
  output logic [1:0] current_limit_level,
  output logic limit_enable,
  output logic line_pull_down_on,
  output logic line_pull_up_on,
  output logic aux_regulator_off,
  output logic wake_detect_on,
  output logic rx_out,
  output logic rx_oe,
  output logic line_current_reduce,
  output logic driver_fault_flag
);
  logic [`LCR_SYNC_W-1:0] sync1_reg;
  logic [`LCR_SYNC_W-1:0] sync2_reg;
  logic [7:0] limit_cfg_reg;
  logic [7:0] control_reg;
  logic [7:0] driver_cfg_reg;
  logic [7:0] rd_data;
  logic [4:0] bus_addr;
  logic wr_pulse;
  logic [7:0] wr_data;
  logic soft_rst;
  logic sw_rearm;
  logic allowed;
  logic fault_flag;
  logic [FILT_W-1:0] filt_cnt_reg;
  logic filt_reg;
  logic rx_line;
  logic tx_data;

  if (GLITCH_CYC < 2 || GLITCH_CYC >= 2**FILT_W) begin : g_bad_glitch
    $error("Glitch filter count does not fit its counter");
  end

  // Two stages before any logic looks at a pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= `LCR_SYNC_RST;
      sync2_reg <= `LCR_SYNC_RST;
    end else begin
      sync1_reg <= {thermal_overload, overcurrent, line_in, tx_in, sdi, cs_n, sclk};
      sync2_reg <= sync1_reg;
    end
  end

  lcr_spi_port u_spi (
    .clk(clk),
    .rst_n(rst_n),
    .sclk_s(sync2_reg[`LCR_SY_SCLK]),
    .cs_n_s(sync2_reg[`LCR_SY_CS]),
    .sdi_s(sync2_reg[`LCR_SY_SDI]),
    .rd_data(rd_data),
    .addr(bus_addr),
    .wr_pulse(wr_pulse),
    .wr_data(wr_data),
    .sdo(sdo),
    .sdo_oe(sdo_oe)
  );

  assign soft_rst = wr_pulse && bus_addr == `LCR_ADDR_MODE && wr_data[`LCR_MODE_RST];
  assign sw_rearm = wr_pulse && bus_addr == `LCR_ADDR_DRV && wr_data[`LCR_DRV_EN];

  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      limit_cfg_reg <= `LCR_CFG_RESET;
      control_reg <= `LCR_CFG_RESET;
      driver_cfg_reg <= `LCR_CFG_RESET;
    end else if (wr_pulse) begin
      case (bus_addr)
        `LCR_ADDR_LIMIT: limit_cfg_reg <= wr_data;
        `LCR_ADDR_CTRL: control_reg <= wr_data & `LCR_CTRL_MASK;
        `LCR_ADDR_DRV: driver_cfg_reg <= wr_data;
        default: ;
      endcase
    end
  end

  // Unmapped and write-only locations read as zero
  always_comb begin
    rd_data = 8'h00;
    case (bus_addr)
      // fault visible, read has no effect
      `LCR_ADDR_STATUS: rd_data[`LCR_STATUS_FAULT] = fault_flag;
      `LCR_ADDR_LIMIT: rd_data = limit_cfg_reg;
      `LCR_ADDR_CTRL: rd_data = control_reg;
      `LCR_ADDR_DRV: rd_data = driver_cfg_reg;
      default: rd_data = 8'h00;
    endcase
  end

  lcr_fault_ctrl #(
    .CNT_W(CNT_W),
    .BLANK_CYC_0(BLANK_CYC_0),
    .BLANK_CYC_1(BLANK_CYC_1),
    .BLANK_CYC_2(BLANK_CYC_2),
    .BLANK_CYC_3(BLANK_CYC_3),
    .OFF_CYC_0(OFF_CYC_0),
    .OFF_CYC_1(OFF_CYC_1),
    .OFF_CYC_2(OFF_CYC_2),
    .OFF_CYC_3(OFF_CYC_3)
  ) u_fault (
    .clk(clk),
    .rst_n(rst_n),
    .cfg_reset(soft_rst),
    .overcurrent(sync2_reg[`LCR_SY_OC]),
    .thermal(sync2_reg[`LCR_SY_TH]),
    .drive_on(line_driver_on),
    .retry_en(limit_cfg_reg[`LCR_LIM_RETRY]),
    .blank_sel(limit_cfg_reg[`LCR_LIM_BLANK]),
    .off_sel(limit_cfg_reg[`LCR_LIM_OFF]),
    .sw_rearm(sw_rearm),
    .allowed(allowed),
    .fault_flag(fault_flag)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filt_cnt_reg <= '0;
      filt_reg <= 1'b0;
    end else if (sync2_reg[`LCR_SY_LINE] == filt_reg) begin
      filt_cnt_reg <= '0;
    end else if (filt_cnt_reg == FILT_W'(GLITCH_CYC - 1)) begin
      filt_cnt_reg <= '0;
      filt_reg <= sync2_reg[`LCR_SY_LINE];
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 1'b1;
    end
  end

  assign rx_line = control_reg[`LCR_CTRL_FILTER] ? filt_reg : sync2_reg[`LCR_SY_LINE];
  assign tx_data = sync2_reg[`LCR_SY_TX] | control_reg[`LCR_CTRL_LEVEL];

  // Limit and edge controls for the analog driver
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      current_limit_level <= 2'h0;
      limit_enable <= 1'b0;
      driver_edge_rate <= 2'h0;
    end else begin
      current_limit_level <= limit_cfg_reg[`LCR_LIM_LEVEL];
      limit_enable <= ~limit_cfg_reg[`LCR_LIM_DIS];
      driver_edge_rate <= limit_cfg_reg[`LCR_LIM_DIS] ? `LCR_EDGE_FASTEST
                                                       : driver_cfg_reg[`LCR_DRV_EDGE];
    end
  end

  // Driver topology, level and enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_mode <= DM_SOURCE;
      line_pull_down_on <= 1'b0;
      line_pull_up_on <= 1'b0;
      line_driver_on <= 1'b0;
      driver_level <= 1'b0;
    end else begin
      if (driver_cfg_reg[`LCR_DRV_PP]) begin
        drive_mode <= DM_PUSH_PULL;
      end else begin
        drive_mode <= driver_cfg_reg[`LCR_DRV_SINK] ? DM_SINK : DM_SOURCE;
      end
      line_pull_down_on <= driver_cfg_reg[`LCR_DRV_PD];
      line_pull_up_on <= driver_cfg_reg[`LCR_DRV_PU];
      line_driver_on <= driver_cfg_reg[`LCR_DRV_EN] & allowed;
      driver_level <= driver_cfg_reg[`LCR_DRV_POL] ? tx_data : ~tx_data;
    end
  end

  // Receiver and supply controls, and the fault status output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_out <= 1'b0;
      rx_oe <= 1'b0;
      line_current_reduce <= 1'b0;
      aux_regulator_off <= 1'b0;
      wake_detect_on <= 1'b0;
      driver_fault_flag <= 1'b0;
    end else begin
      rx_out <= driver_cfg_reg[`LCR_DRV_POL] ? rx_line : ~rx_line;
      rx_oe <= ~control_reg[`LCR_CTRL_RX_OFF];
      line_current_reduce <= control_reg[`LCR_CTRL_RX_OFF];
      aux_regulator_off <= control_reg[`LCR_CTRL_AUX_OFF];
      wake_detect_on <= ~control_reg[`LCR_CTRL_WAKE_OFF];
      driver_fault_flag <= fault_flag;
    end
  end

  AST_LIMIT_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pulse && bus_addr == `LCR_ADDR_LIMIT |-> ##2
    current_limit_level == $past(wr_data[7:6], 2)) else $error("Limit level not applied");
  AST_LIMIT_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    limit_cfg_reg[`LCR_LIM_DIS] |=> !limit_enable && driver_edge_rate == `LCR_EDGE_FASTEST)
    else $error("Limit disable did not force fast edge");
  AST_EDGE_RATE: assert property (@(posedge clk) disable iff (!rst_n)
    !limit_cfg_reg[`LCR_LIM_DIS] && $stable(driver_cfg_reg) |=>
    driver_edge_rate == $past(driver_cfg_reg[7:6])) else $error("Edge rate wrong");
  AST_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pulse && bus_addr == `LCR_ADDR_DRV |-> ##2 drive_mode == ($past(wr_data[2], 2)
    ? DM_PUSH_PULL : ($past(wr_data[3], 2) ? DM_SINK : DM_SOURCE)))
    else $error("Drive mode wrong");
  AST_RX_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pulse && bus_addr == `LCR_ADDR_CTRL && wr_data[3] |-> ##2 !rx_oe
    && line_current_reduce) else $error("Receive output not floated");
  AST_CTRL_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pulse && bus_addr == `LCR_ADDR_CTRL |-> ##2 aux_regulator_off == $past(wr_data[7], 2)
    && wake_detect_on == !$past(wr_data[6], 2)) else $error("Control bits wrong");
  AST_DRV_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    line_driver_on |-> $past(driver_cfg_reg[0]) && $past(allowed))
    else $error("Driver on without enable");
  AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && !$past(driver_cfg_reg[1]) && !$past(control_reg[0]) |-> driver_level
    == !$past(sync2_reg[`LCR_SY_TX])) else $error("Line level not inverted");
  AST_SOFT_RST: assert property (@(posedge clk) disable iff (!rst_n)
    soft_rst |=> limit_cfg_reg == `LCR_CFG_RESET && control_reg == `LCR_CFG_RESET
    && driver_cfg_reg == `LCR_CFG_RESET ##1 !line_driver_on) else $error("Soft reset missed");
  AST_FAULT_STATUS: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(fault_flag) |=> driver_fault_flag ##1 !line_driver_on)
    else $error("Fault not reported or driver still on");
  COV_FAULT: cover property (@(posedge clk) disable iff (!rst_n) $rose(driver_fault_flag));
  COV_SOFT_RST: cover property (@(posedge clk) disable iff (!rst_n) soft_rst);
  COV_FILTER: cover property (@(posedge clk) disable iff (!rst_n)
    control_reg[`LCR_CTRL_FILTER] && $changed(filt_reg));
endmodule

// [testbench/lcr_line_model.sv]
// Behavioural line and load seen by the driver, with a commanded short.
// Assumes the bench owns short_cmd; pulls set the level while undriven.
`timescale 1ns/100ps
module lcr_line_model (
  input wire logic clk,
  input wire logic driver_level,
  input wire logic line_driver_on,
  input wire logic line_pull_up_on,
  input wire logic line_pull_down_on,
  input wire logic short_cmd,
  output logic line_in,
  output logic overcurrent
);
  logic toggle_reg = 1'b0;
  always_ff @(posedge clk) begin
    toggle_reg <= ~toggle_reg;
  end
  // A short only draws current while the driver is on
  assign overcurrent = short_cmd & line_driver_on;
  // Undriven, unpulled line wanders so no stale level can pass
  always_comb begin
    if (line_driver_on) begin
      line_in = driver_level;
    end else if (line_pull_up_on) begin
      line_in = 1'b1;
    end else if (line_pull_down_on) begin
      line_in = 1'b0;
    end else begin
      line_in = toggle_reg;
    end
  end
endmodule

// [testbench/tb.sv]
// Self-checking bench for the line driver register bank.
// Assumes the line model beside it; blanking and off-times are shortened.
`timescale 1ns/100ps
`define CMP(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb import lcr_pkg::*;;
  localparam int BLK[4] = '{20, 30, 40, 50};
  localparam int OFF[4] = '{100, 150, 200, 250};
  logic clk = 1'b0, rst_n = 1'b0, sclk = 1'b0, cs_n = 1'b1, sdi = 1'b0;
  logic tx_in = 1'b0, thermal = 1'b0, short_cmd = 1'b0, line_in, overcurrent;
  logic sdo, sdo_oe, line_driver_on, driver_level, limit_enable, line_pull_down_on;
  logic line_pull_up_on, aux_regulator_off, wake_detect_on, rx_out, rx_oe;
  logic line_current_reduce, driver_fault_flag, t, seen, oe_seen;
  logic [1:0] driver_edge_rate, current_limit_level;
  lcr_drive_mode_type drive_mode;
  logic [15:0] outs, got, exp_v, q[$];
  logic [7:0] a, c, d, r;
  int n_errors = 0, cmp_count = 0, n;
  event ev;
  assign outs = {1'b0, current_limit_level, limit_enable, driver_edge_rate, line_pull_down_on,
    line_pull_up_on, drive_mode, line_driver_on, aux_regulator_off, wake_detect_on, rx_oe,
    line_current_reduce, driver_level};
  lcr_line_driver_regs #(.GLITCH_CYC(4), .BLANK_CYC_0(BLK[0]), .BLANK_CYC_1(BLK[1]),
    .BLANK_CYC_2(BLK[2]), .BLANK_CYC_3(BLK[3]), .OFF_CYC_0(OFF[0]), .OFF_CYC_1(OFF[1]),
    .OFF_CYC_2(OFF[2]), .OFF_CYC_3(OFF[3])) uut (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .tx_in(tx_in), .line_in(line_in), .overcurrent(overcurrent),
    .thermal_overload(thermal), .sdo(sdo), .sdo_oe(sdo_oe), .line_driver_on(line_driver_on),
    .driver_level(driver_level), .drive_mode(drive_mode), .driver_edge_rate(driver_edge_rate),
    .current_limit_level(current_limit_level), .limit_enable(limit_enable),
    .line_pull_down_on(line_pull_down_on), .line_pull_up_on(line_pull_up_on),
    .aux_regulator_off(aux_regulator_off), .wake_detect_on(wake_detect_on), .rx_out(rx_out),
    .rx_oe(rx_oe), .line_current_reduce(line_current_reduce),
    .driver_fault_flag(driver_fault_flag));
  lcr_line_model line_model (.clk(clk), .driver_level(driver_level),
    .line_driver_on(line_driver_on), .line_pull_up_on(line_pull_up_on),
    .line_pull_down_on(line_pull_down_on), .short_cmd(short_cmd), .line_in(line_in),
    .overcurrent(overcurrent));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic end_of_test;
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Sclk half periods of 5 clk high and 6 clk low keep above the synchroniser's minimum
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rdat);
    logic [15:0] f;
    f = {cmd, dat};
    rdat = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk) sdi <= f[i];
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
      repeat (5) @(posedge clk);
      if (i < 8) rdat[i] = sdo;
      if (i == 0) oe_seen = sdo_oe;
      sclk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    q.push_back(exp);
    got = act;
    ->ev;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] adr, input logic [7:0] dat);
    xfer({3'b000, adr}, dat, r);
  endtask
  task automatic rd(input logic [4:0] adr, input logic [7:0] exp);
    xfer({3'b100, adr}, 8'h00, r);
    // Output enable high inside the frame, low again after it
    chk({6'h00, sdo_oe, oe_seen, r}, {8'h01, exp});
  endtask
  task automatic wait_flag(input logic lvl);
    n = 0;
    while (driver_fault_flag !== lvl && n < 5000) begin
      @(posedge clk);
      n++;
    end
  endtask
  always @(ev) begin
    exp_v = q.pop_front();
    `CMP(got, exp_v)
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h7975));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(outs, 16'h100D);
    for (int k = 5; k < 8; k++) rd(k[4:0], 8'h00);
    for (int k = 0; k < 6; k++) begin
      a = {k[1:0], k[2], 5'($urandom)};
      c = 8'($urandom);
      d = {k[1:0], 2'($urandom), k[1:0], 2'($urandom)};
      t = 1'($urandom);
      tx_in <= t;
      wr(5'h05, a);
      wr(5'h06, c);
      wr(5'h07, d);
      chk(outs, {1'b0, a[7:6], !a[5], a[5] ? 2'b00 : d[7:6], d[5:4],
        d[2] ? 2'h2 : {1'b0, d[3]}, d[0], c[7], !c[6], !c[3], c[3],
        (t | c[0]) ^ !d[1]});
      rd(5'h05, a);
      rd(5'h06, c & 8'hCD);
      rd(5'h07, d);
    end
    wr(5'h07, 8'h03);
    for (int f = 0; f < 2; f++) begin
      wr(5'h06, {5'h00, f[0], 2'b00});
      tx_in <= 1'b0;
      repeat (20) @(posedge clk);
      tx_in <= 1'b1;
      repeat (2) @(posedge clk);
      tx_in <= 1'b0;
      seen = 1'b0;
      repeat (20) @(posedge clk) seen |= rx_out;
      chk({15'h0, seen}, {15'h0, !f[0]});
    end
    wr(5'h07, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(5'h05, {3'b000, k[1:0], k[1:0], 1'b1});
      short_cmd <= 1'b1;
      repeat (BLK[k] / 2) @(posedge clk);
      short_cmd <= 1'b0;
      repeat (BLK[k] + 20) @(posedge clk);
      chk({15'h0, driver_fault_flag}, 16'h0000);
      short_cmd <= 1'b1;
      wait_flag(1'b1);
      chk({14'h0, line_driver_on, n > BLK[k] && n <= BLK[k] + 10}, 16'h0001);
      short_cmd <= 1'b0;
      wait_flag(1'b0);
      chk({15'h0, n + 3 >= OFF[k] && n <= OFF[k] + 10}, 16'h0001);
      repeat (4) @(posedge clk);
      chk({15'h0, line_driver_on}, 16'h0001);
    end
    wr(5'h05, 8'h00);
    short_cmd <= 1'b1;
    wait_flag(1'b1);
    short_cmd <= 1'b0;
    rd(5'h02, 8'h10);
    rd(5'h02, 8'h10);
    chk({15'h0, line_driver_on}, 16'h0000);
    wr(5'h07, 8'h01);
    repeat (4) @(posedge clk);
    chk({14'h0, line_driver_on, driver_fault_flag}, 16'h0002);
    thermal <= 1'b1;
    repeat (10) @(posedge clk);
    chk({15'h0, driver_fault_flag}, 16'h0001);
    thermal <= 1'b0;
    wr(5'h04, 8'h80);
    repeat (4) @(posedge clk);
    chk({15'h0, driver_fault_flag}, 16'h0000);
    rd(5'h07, 8'h00);
    rd(5'h05, 8'h00);
    rd(5'h04, 8'h00);
    rd(5'h1F, 8'h00);
    wr(5'h02, 8'hFF);
    rd(5'h02, 8'h00);
    end_of_test;
  end
endmodule
